// file: core/ppsr_pkg.sv
// Constants, carriers and command codes for protection status reporting.
// Notes on behaviour
// - Condition register returns live 32-bit hardware status.
// - Condition bits follow hardware, never hold history.
// - One means condition present, zero means normal.
// - Bits 3,4,5,7: overvoltage, temperature, shutdown, programming.
// - Bits 8-16: fan through follower system faults.
// - Bits 18-20: sense, regulation, feedback imbalance faults.
// - Bit 17 and bits 21-31 read zero.
// - Reading event register clears it.
// - Clear-status and reset commands clear event register.
// - Event bit sets only when enabled and occurring.
// - Set event bits latch until read or cleared.
// - Host writes mask; device stores and returns it.
// - Mask filters events and gates mode-bit shutdown; detection keeps working.
// - All conditions shut down except unenabled mode bits.
// - Recorded events summarise into status byte bit 1.
// - Trigger input high starts the output ramp.
// - Trigger output pulses low on output change.
// - Remote contact ANDs with command output enable.
// - Isolated remote inputs, like the contact, turn the output on only with the command output enable.
package ppsr_pkg;

  localparam int PPSR_DATA_W = 32;
  localparam logic [31:0] PPSR_COND_VALID_MASK = 32'h001dffff;
  localparam logic [31:0] PPSR_MODE_BITS_MASK = 32'h00000047;
  localparam logic [31:0] PPSR_MASK_RESET = 32'h00000000;
  localparam logic [31:0] PPSR_EVENT_RESET = 32'h00000000;
  localparam int PPSR_STB_PROT_BIT = 1;
  localparam int PPSR_CLK_PERIOD_NS = 10;
  localparam int PPSR_TRIG_OUT_NS = 1000;
  localparam int PPSR_TRIG_OUT_CYCLES = (PPSR_TRIG_OUT_NS + PPSR_CLK_PERIOD_NS - 1) / PPSR_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    cmd_condition_query,
    cmd_event_query,
    cmd_enable_query,
    cmd_enable_set,
    cmd_clear_status,
    cmd_reset
  } ppsr_cmd_code_t;

  typedef struct packed {
    logic valid;
    ppsr_cmd_code_t code;
    logic [31:0] data;
  } ppsr_cmd_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } ppsr_resp_t;

  typedef struct packed {
    logic current_feedback_imbalance;
    logic regulation_fault;
    logic remote_sense_fault;
    logic follower_system_fault;
    logic parallel_cable_fault;
    logic line_status_changed;
    logic auxiliary_supply_fault;
    logic overcurrent_fault_flag;
    logic power_factor_module_fault;
    logic dc_module_fault;
    logic line_drop_fault;
    logic fan_fault;
    logic remote_programming_error;
    logic foldback_mode;
    logic external_shutdown;
    logic over_temperature_fault;
    logic overvoltage_fault;
    logic constant_power_mode;
    logic constant_current_mode;
    logic constant_voltage_mode;
  } ppsr_fault_t;

endpackage

// file: core/ppsr_event_latch.sv
// Sticky event bits gated by the enable mask.
`timescale 1ns/1ps
module ppsr_event_latch
  import ppsr_pkg::*;
#(
  parameter int WIDTH = PPSR_DATA_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] condition,
  input wire logic [WIDTH-1:0] mask,
  input wire logic clear,
  output logic [WIDTH-1:0] event_bits
);

  // --------------------------------------------------------------------
  // Per-bit latch
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic next_bit;
      always_comb begin
        // A new event in the clearing cycle survives, so nothing is missed.
        next_bit = (event_bits[i] & ~clear) | (condition[i] & mask[i]);
      end
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          event_bits[i] <= PPSR_EVENT_RESET[i];
        end else begin
          event_bits[i] <= next_bit;
        end
      end
    end
  endgenerate

endmodule

// file: core/ppsr_output_gate.sv
// Trigger lines and remote output on/off gating.
`timescale 1ns/1ps
module ppsr_output_gate
  import ppsr_pkg::*;
#(
  parameter int TRIG_CYCLES = PPSR_TRIG_OUT_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic trigger_in,
  input wire logic setpoint_changed,
  input wire logic contact_closed,
  input wire logic isolated_high_voltage_output_switch,
  input wire logic isolated_logic_output_switch,
  input wire logic program_output_on,
  input wire logic shutdown,
  output logic ramp_start,
  output logic trigger_out_n,
  output logic output_on
);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  logic trigger_seen;
  logic [15:0] pulse_count;
  logic next_trigger_seen;
  logic next_ramp_start;
  logic next_output_on;
  logic [15:0] next_pulse_count;
  logic next_trigger_out_n;

  always_comb begin
    next_trigger_seen = trigger_in;
    next_ramp_start = trigger_in & ~trigger_seen;
    // Any remote source may request the output; the command enable must agree.
    next_output_on = program_output_on & ~shutdown &
                     (contact_closed | isolated_high_voltage_output_switch |
                      isolated_logic_output_switch);
    next_pulse_count = pulse_count;
    if ((next_output_on != output_on) || setpoint_changed) begin
      next_pulse_count = 16'(TRIG_CYCLES);
    end else if (pulse_count != 16'h0000) begin
      next_pulse_count = pulse_count - 16'h0001;
    end
    next_trigger_out_n = (next_pulse_count == 16'h0000);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      trigger_seen <= 1'b0;
      ramp_start <= 1'b0;
      output_on <= 1'b0;
      pulse_count <= 16'h0000;
      trigger_out_n <= 1'b1;
    end else begin
      trigger_seen <= next_trigger_seen;
      ramp_start <= next_ramp_start;
      output_on <= next_output_on;
      pulse_count <= next_pulse_count;
      trigger_out_n <= next_trigger_out_n;
    end
  end

endmodule

// file: core/ppsr_top.sv
// Protection condition, event and enable registers with output control.
`timescale 1ns/1ps
module ppsr_top
  import ppsr_pkg::*;
#(
  parameter int TRIG_CYCLES = PPSR_TRIG_OUT_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire ppsr_fault_t hw_faults,
  input wire ppsr_cmd_t cmd,
  output ppsr_resp_t resp,
  output logic protection_summary,
  output logic shutdown,
  input wire logic trigger_in,
  input wire logic setpoint_changed,
  input wire logic contact_closed,
  input wire logic isolated_high_voltage_output_switch,
  input wire logic isolated_logic_output_switch,
  input wire logic program_output_on,
  output logic ramp_start,
  output logic trigger_out_n,
  output logic output_on
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] pack_condition(input ppsr_fault_t f);
    logic [31:0] w;
    w = 32'h00000000;
    w[0] = f.constant_voltage_mode;
    w[1] = f.constant_current_mode;
    w[2] = f.constant_power_mode;
    w[3] = f.overvoltage_fault;
    w[4] = f.over_temperature_fault;
    w[5] = f.external_shutdown;
    w[6] = f.foldback_mode;
    w[7] = f.remote_programming_error;
    w[8] = f.fan_fault;
    w[9] = f.line_drop_fault;
    w[10] = f.dc_module_fault;
    w[11] = f.power_factor_module_fault;
    w[12] = f.overcurrent_fault_flag;
    w[13] = f.auxiliary_supply_fault;
    w[14] = f.line_status_changed;
    w[15] = f.parallel_cable_fault;
    w[16] = f.follower_system_fault;
    w[18] = f.remote_sense_fault;
    w[19] = f.regulation_fault;
    w[20] = f.current_feedback_imbalance;
    return w & PPSR_COND_VALID_MASK;
  endfunction

  function automatic logic clears_events(input ppsr_cmd_t c);
    return c.valid && (c.code == cmd_event_query || c.code == cmd_clear_status ||
                       c.code == cmd_reset);
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [31:0] protection_live_condition;
  logic [31:0] protection_event_mask;
  logic [31:0] protection_latched_event;
  logic [31:0] next_live_condition;
  logic [31:0] next_event_mask;
  ppsr_resp_t next_resp;
  logic next_summary;
  logic next_shutdown;
  logic event_clear;

  always_comb begin
    // Sampled every cycle with no hold, so it is safe to poll.
    next_live_condition = pack_condition(hw_faults);
    next_event_mask = protection_event_mask;
    next_resp = '0;
    event_clear = clears_events(cmd);
    if (cmd.valid) begin
      unique case (cmd.code)
        cmd_condition_query: begin
          next_resp.valid = 1'b1;
          next_resp.data = protection_live_condition;
        end
        cmd_event_query: begin
          next_resp.valid = 1'b1;
          next_resp.data = protection_latched_event;
        end
        cmd_enable_query: begin
          next_resp.valid = 1'b1;
          next_resp.data = protection_event_mask;
        end
        cmd_enable_set: begin
          next_event_mask = cmd.data & PPSR_COND_VALID_MASK;
        end
        cmd_clear_status: begin
          next_resp = '0;
        end
        cmd_reset: begin
          next_resp = '0;
        end
        default: begin
          next_resp = '0;
        end
      endcase
    end
    next_summary = |protection_latched_event;
    // Detection is never masked; the mask only lets enabled mode bits trip.
    next_shutdown = |(protection_live_condition &
                      (~PPSR_MODE_BITS_MASK | protection_event_mask));
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      protection_live_condition <= 32'h00000000;
      protection_event_mask <= PPSR_MASK_RESET;
      resp <= '0;
      protection_summary <= 1'b0;
      shutdown <= 1'b0;
    end else begin
      protection_live_condition <= next_live_condition;
      protection_event_mask <= next_event_mask;
      resp <= next_resp;
      protection_summary <= next_summary;
      shutdown <= next_shutdown;
    end
  end

  // --------------------------------------------------------------------
  // Event latch and output control
  // --------------------------------------------------------------------
  ppsr_event_latch #(
    .WIDTH(PPSR_DATA_W)
  ) u_event_latch (
    .clock(clock),
    .reset_n(reset_n),
    .condition(protection_live_condition),
    .mask(protection_event_mask),
    .clear(event_clear),
    .event_bits(protection_latched_event)
  );

  ppsr_output_gate #(
    .TRIG_CYCLES(TRIG_CYCLES)
  ) u_output_gate (
    .clock(clock),
    .reset_n(reset_n),
    .trigger_in(trigger_in),
    .setpoint_changed(setpoint_changed),
    .contact_closed(contact_closed),
    .isolated_high_voltage_output_switch(isolated_high_voltage_output_switch),
    .isolated_logic_output_switch(isolated_logic_output_switch),
    .program_output_on(program_output_on),
    .shutdown(shutdown),
    .ramp_start(ramp_start),
    .trigger_out_n(trigger_out_n),
    .output_on(output_on)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_cond_follows_hw: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n ##1 1'b1 |=> protection_live_condition == pack_condition($past(hw_faults)))
    else $error("condition register does not follow hardware");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    ((protection_live_condition | protection_latched_event | protection_event_mask) &
     ~PPSR_COND_VALID_MASK) == 32'h00000000)
    else $error("reserved status bits are not zero");

  a_event_read_data: assert property (@(posedge clock) disable iff (!reset_n)
    cmd.valid && cmd.code == cmd_event_query |=>
      resp.valid && resp.data == $past(protection_latched_event))
    else $error("event query returned wrong value");

  a_event_clears: assert property (@(posedge clock) disable iff (!reset_n)
    clears_events(cmd) && (protection_live_condition & protection_event_mask) == 32'h00000000 |=>
      protection_latched_event == 32'h00000000)
    else $error("event register not cleared");

  a_event_needs_enable: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n ##1 1'b1 |-> (protection_latched_event & ~$past(protection_latched_event) &
      ~($past(protection_live_condition) & $past(protection_event_mask))) == 32'h00000000)
    else $error("event bit set without enabled condition");

  a_event_holds: assert property (@(posedge clock) disable iff (!reset_n)
    !event_clear ##1 1'b1 |-> (protection_latched_event & $past(protection_latched_event)) ==
      $past(protection_latched_event))
    else $error("latched event bit dropped without clear");

  a_set_beats_clear: assert property (@(posedge clock) disable iff (!reset_n)
    event_clear |=> (protection_latched_event &
      $past(protection_live_condition & protection_event_mask)) ==
      $past(protection_live_condition & protection_event_mask))
    else $error("same-cycle event lost to clear");

  // The host leaves one idle cycle between commands, so the query follows the write two edges later.
  a_mask_roundtrip: assert property (@(posedge clock) disable iff (!reset_n)
    cmd.valid && cmd.code == cmd_enable_set ##1 !cmd.valid ##1 cmd.valid && cmd.code == cmd_enable_query |=>
      resp.data == ($past(cmd.data, 3) & PPSR_COND_VALID_MASK))
    else $error("mask readback differs from write");

  a_summary_or: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n |=> protection_summary == (|$past(protection_latched_event)))
    else $error("summary flag not OR of events");

  a_fault_shutdown: assert property (@(posedge clock) disable iff (!reset_n)
    (protection_live_condition & ~PPSR_MODE_BITS_MASK) != 32'h00000000 |=> shutdown)
    else $error("fault did not force shutdown");

  a_mode_no_trip: assert property (@(posedge clock) disable iff (!reset_n)
    (protection_live_condition & ~(PPSR_MODE_BITS_MASK & ~protection_event_mask)) == 32'h00000000
      |=> !shutdown)
    else $error("unenabled mode bit caused shutdown");

  a_trigger_ramp: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(trigger_in) |=> ramp_start ##1 !ramp_start)
    else $error("trigger input did not start ramp");

  a_trig_out_low: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(output_on) |-> !trigger_out_n [*2])
    else $error("trigger output not low on output change");

  a_remote_and: assert property (@(posedge clock) disable iff (!reset_n)
    output_on |-> $past(program_output_on) && !$past(shutdown) &&
      ($past(contact_closed) || $past(isolated_high_voltage_output_switch) ||
       $past(isolated_logic_output_switch)))
    else $error("output on without both enables");

endmodule

// file: bench/ppsr_host_model.sv
// Remote host model that issues status commands and collects the answers.
`timescale 1ns/1ps
module ppsr_host_model
  import ppsr_pkg::*;
(
  input wire logic clock,
  output ppsr_cmd_t cmd,
  input wire ppsr_resp_t resp
);

  initial begin
    cmd = '0;
  end

  // ----------------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------------
  // The strobe drops at the edge that takes the command. Released data is inverted so a stale word never looks valid.
  // Mask writes are the host's share of event reporting; the service request mask lies outside this block.
  task automatic issue(input ppsr_cmd_code_t code, input logic [31:0] data, output logic rvalid,
                       output logic [31:0] rdata);
    @(posedge clock);
    cmd <= '{valid: 1'b1, code: code, data: data};
    @(posedge clock);
    cmd <= '{valid: 1'b0, code: code, data: ~data};
    #1;
    rvalid = resp.valid;
    rdata = resp.data;
  endtask

endmodule

// file: bench/testbench.sv
// Self-checking testbench for protection status reporting.
`timescale 1ns/1ps
module testbench
  import ppsr_pkg::*;
;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int TRIG = 4;
  localparam int LIMIT = 5000;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ppsr_fault_t hw_faults = '0;
  ppsr_cmd_t cmd;
  ppsr_resp_t resp;
  logic protection_summary, shutdown, ramp_start, trigger_out_n, output_on;
  logic trigger_in = 1'b0;
  logic setpoint_changed = 1'b0;
  logic contact_closed = 1'b0;
  logic hv_switch = 1'b0;
  logic logic_switch = 1'b0;
  logic program_output_on = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic rv;
  logic [31:0] rd;
  logic [31:0] exp;
  ppsr_cmd_code_t code;
  localparam ppsr_fault_t FOLD = ppsr_fault_t'(20'h00040);

  always #5 clock = ~clock;

  ppsr_host_model i_host (.clock(clock), .cmd(cmd), .resp(resp));

  ppsr_top #(.TRIG_CYCLES(TRIG)) i_dut (
    .clock(clock),
    .reset_n(reset_n),
    .hw_faults(hw_faults),
    .cmd(cmd),
    .resp(resp),
    .protection_summary(protection_summary),
    .shutdown(shutdown),
    .trigger_in(trigger_in),
    .setpoint_changed(setpoint_changed),
    .contact_closed(contact_closed),
    .isolated_high_voltage_output_switch(hv_switch),
    .isolated_logic_output_switch(logic_switch),
    .program_output_on(program_output_on),
    .ramp_start(ramp_start),
    .trigger_out_n(trigger_out_n),
    .output_on(output_on)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // The fault carrier skips the unused bit 17 of the register layout.
  function automatic logic [31:0] reg_of(input logic [19:0] f);
    return {11'h000, f[19:17], 1'b0, f[16:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic ask(input ppsr_cmd_code_t c, input logic [31:0] expv);
    i_host.issue(c, 32'h0, rv, rd);
    check({31'h0, rv}, 32'h1, "answer strobe");
    check(rd, expv, "answer data");
  endtask

  task automatic put(input ppsr_cmd_code_t c, input logic [31:0] data);
    i_host.issue(c, data, rv, rd);
    check({31'h0, rv}, 32'h0, "unexpected answer strobe");
    check(rd, 32'h0, "idle answer data");
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("Error at %0t: run did not finish in time", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    cyc(1);
    check({28'h0, protection_summary, shutdown, output_on, trigger_out_n}, 32'h1, "reset outputs");
    ask(cmd_condition_query, 32'h0);
    ask(cmd_event_query, 32'h0);
    ask(cmd_enable_query, 32'h0);
    put(cmd_enable_set, 32'hffffffff);
    ask(cmd_enable_query, 32'h001dffff);
    put(cmd_enable_set, 32'h0);
    put(ppsr_cmd_code_t'(3'h6), 32'h0);
    put(ppsr_cmd_code_t'(3'h7), 32'h0);
    // Every bit alone, with the mask cleared so only the live path reacts.
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      hw_faults <= ppsr_fault_t'(20'h1 << i);
      cyc(4);
      exp = reg_of(20'h1 << i);
      check({31'h0, shutdown}, {31'h0, ~|(exp & PPSR_MODE_BITS_MASK)}, "shutdown per bit");
      ask(cmd_condition_query, exp);
      ask(cmd_event_query, 32'h0);
    end
    @(posedge clock);
    hw_faults <= '0;
    cyc(4);
    ask(cmd_condition_query, 32'h0);
    // Enabled mode bit: latches, shuts down, raises the summary.
    put(cmd_enable_set, 32'h40);
    @(posedge clock);
    hw_faults <= FOLD;
    cyc(4);
    check({31'h0, shutdown}, 32'h1, "enabled mode shutdown");
    check({31'h0, protection_summary}, 32'h1, "summary set");
    @(posedge clock);
    hw_faults <= '0;
    cyc(4);
    check({31'h0, shutdown}, 32'h0, "shutdown follows live state");
    ask(cmd_event_query, 32'h40);
    ask(cmd_event_query, 32'h0);
    cyc(2);
    check({31'h0, protection_summary}, 32'h0, "summary cleared");
    // A condition still present sets the bit again over the clearing read.
    @(posedge clock);
    hw_faults <= FOLD;
    cyc(4);
    ask(cmd_event_query, 32'h40);
    ask(cmd_event_query, 32'h40);
    @(posedge clock);
    hw_faults <= '0;
    cyc(4);
    ask(cmd_event_query, 32'h40);
    for (int k = 0; k < 2; k++) begin
      code = (k == 0) ? cmd_clear_status : cmd_reset;
      @(posedge clock);
      hw_faults <= FOLD;
      @(posedge clock);
      hw_faults <= '0;
      cyc(4);
      check({31'h0, protection_summary}, 32'h1, "summary before clear");
      put(code, 32'h0);
      ask(cmd_event_query, 32'h0);
      ask(cmd_enable_query, 32'h40);
    end
    // Trigger lines.
    @(posedge clock);
    trigger_in <= 1'b1;
    cyc(1);
    check({31'h0, ramp_start}, 32'h1, "ramp start pulse");
    cyc(1);
    check({31'h0, ramp_start}, 32'h0, "ramp start ends");
    @(posedge clock);
    setpoint_changed <= 1'b1;
    @(posedge clock);
    setpoint_changed <= 1'b0;
    #1;
    check({31'h0, trigger_out_n}, 32'h0, "trigger out low");
    cyc(TRIG - 1);
    check({31'h0, trigger_out_n}, 32'h0, "trigger out still low");
    cyc(1);
    check({31'h0, trigger_out_n}, 32'h1, "trigger out released");
    // Output gating over every combination of the command enable and the three remote inputs, with shutdown low.
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      {program_output_on, contact_closed, hv_switch, logic_switch} <= 4'(k);
      cyc(2);
      check({31'h0, output_on}, {31'h0, 1'(k >> 3) & (|3'(k))}, "output gating");
    end
    @(posedge clock);
    hw_faults <= ppsr_fault_t'(20'h00008);
    cyc(4);
    check({31'h0, output_on}, 32'h0, "fault forces output off");
    end_of_test();
  end

endmodule
